// ### hdl/cp_pkg.sv
/*
 * cp_pkg: shared constants and types for the charge pump controller.
 * Assumes an APB master with 32-bit data; the control register is one
 * aligned word at four times its printed index.
 */
package cp_pkg;

    // register placement: printed index, byte address is four times it
    localparam logic [15:0] CTRL_INDEX = 16'h100d;
    localparam logic [15:0] CTRL_ADDR  = 16'h4034;

    // field positions inside the control register
    localparam int MODE_LSB    = 6;
    localparam int CLKSEL_BIT  = 5;
    localparam int REQ_BIT     = 2;
    localparam int THR_BIT     = 1;
    localparam int RDY_BIT     = 0;

    // reset values
    localparam logic [1:0] MODE_RST   = 2'h0;
    localparam logic       CLKSEL_RST = 1'h0;

    // pump mode field encodings
    typedef enum logic [1:0] {
        CP_MODE_OFF    = 2'b00,
        CP_MODE_PERIPH = 2'b01,
        CP_MODE_AUTO   = 2'b10,
        CP_MODE_ON     = 2'b11
    } cp_mode_t;

    // pump clock source steering
    typedef enum logic [1:0] {
        CP_CLK_CONV_RC  = 2'b00,
        CP_CLK_SYS_DIV  = 2'b01,
        CP_CLK_INTERNAL = 2'b10
    } cp_clk_src_t;

    // software-written configuration
    typedef struct packed {
        cp_mode_t mode;
        logic     clk_sel;
    } cp_cfg_t;

    // read-only status flags
    typedef struct packed {
        logic request;
        logic threshold;
        logic ready;
    } cp_stat_t;

endpackage : cp_pkg

// ### hdl/cp_charge_pump_ctrl.sv
/*
 * cp_charge_pump_ctrl: mode control, clock steering and status for an
 * on-chip charge pump, with an APB slave holding the control register.
 * Assumes the comparator and settling inputs are asynchronous, and the
 * converter and peripheral signals come from logic on ref_clk.
 */
// The implementer's own choice: the APB slave port.
// Functional notes
// - mode 11 keeps pump on always
// - mode 10: on while supply below threshold
// - mode 01: on if peripheral enabled, supply low
// - mode resets 00; writing 00 stops pump
// - clock select 1 uses internal oscillator
// - select 0: rc idle, system derivative converting
// - threshold flag mirrors supply above threshold
// - ready flag only when pump steady
// - request flag shows peripheral requesting pump
// - register layout: mode 7:6, select 5, flags
module cp_charge_pump_ctrl (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // analog side inputs
    input  wire logic                supply_above_async,
    input  wire logic                pump_settled_async,
    input  wire logic                periph_enabled,
    input  wire logic                periph_request,
    input  wire logic                conversion_running,
    // pump control outputs
    output logic                     pump_on,
    output cp_pkg::cp_clk_src_t      pump_clk_src,
    output logic                     pump_ready_flag
);

    // synchroniser stages and accepted levels
    logic [2:0]          above_sync;
    logic [2:0]          settled_sync;
    logic                above_q;
    logic                settled_q;
    logic                next_above_q;
    logic                next_settled_q;

    // register and status state
    cp_pkg::cp_cfg_t     cfg;
    cp_pkg::cp_cfg_t     next_cfg;
    logic                pump_request_flag;
    logic                next_pump_on;
    logic                next_ready;
    logic                next_request;
    cp_pkg::cp_clk_src_t next_clk_src;

    // bus state
    logic                setup;
    logic                hit;
    logic                wr_take;
    logic                next_pready;
    logic                next_pslverr;
    logic [31:0]         next_prdata;
    cp_pkg::cp_stat_t    stat;

    // accept a new level only once stages two and three agree, so a
    // metastable first stage never reaches the decision logic
    // synchroniser acceptance
    always_comb begin
        next_above_q   = (above_sync[2] == above_sync[1]) ? above_sync[2] : above_q;
        next_settled_q = (settled_sync[2] == settled_sync[1]) ? settled_sync[2] : settled_q;
    end

    // shift the raw inputs through three flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            above_sync   <= 3'h0;
            settled_sync <= 3'h0;
            above_q      <= 1'h0;
            settled_q    <= 1'h0;
        end else begin
            above_sync   <= {above_sync[1:0], supply_above_async};
            settled_sync <= {settled_sync[1:0], pump_settled_async};
            above_q      <= next_above_q;
            settled_q    <= next_settled_q;
        end
    end

    // bus decode; the access phase always completes in one cycle
    assign setup   = psel & ~penable;
    assign hit     = (paddr == cp_pkg::CTRL_ADDR);
    assign wr_take = psel & penable & pready & pwrite & ~pslverr & pstrb[0];

    // status word as software sees it
    // threshold from synced supply
    assign stat = '{request: pump_request_flag, threshold: above_q, ready: pump_ready_flag};

    // configuration write; only the low byte lane carries fields
    // write of mode field
    always_comb begin
        next_cfg = cfg;
        if (wr_take) begin
            next_cfg.mode    = cp_pkg::cp_mode_t'(pwdata[cp_pkg::MODE_LSB +: 2]);
            next_cfg.clk_sel = pwdata[cp_pkg::CLKSEL_BIT];
        end
    end

    // answer computed in setup so pready and data leave flops directly
    // register read layout
    always_comb begin
        next_pready  = setup;
        next_pslverr = setup & ~hit;
        next_prdata  = prdata;
        if (setup) begin
            next_prdata = 32'h0;
            if (hit & ~pwrite) begin
                next_prdata[cp_pkg::MODE_LSB +: 2] = cfg.mode;
                next_prdata[cp_pkg::CLKSEL_BIT]    = cfg.clk_sel;
                next_prdata[cp_pkg::REQ_BIT]       = stat.request;
                next_prdata[cp_pkg::THR_BIT]       = stat.threshold;
                next_prdata[cp_pkg::RDY_BIT]       = stat.ready;
            end
        end
    end

    // register the bus answer and configuration
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0;
            cfg     <= '{mode: cp_pkg::cp_mode_t'(cp_pkg::MODE_RST), clk_sel: cp_pkg::CLKSEL_RST};
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
            cfg     <= next_cfg;
        end
    end

    // pump enable decision from mode, supply and peripheral state
    always_comb begin
        unique case (cfg.mode)
            cp_pkg::CP_MODE_ON:     next_pump_on = 1'b1;
            cp_pkg::CP_MODE_AUTO:   next_pump_on = ~above_q;
            cp_pkg::CP_MODE_PERIPH: next_pump_on = periph_enabled & ~above_q;
            cp_pkg::CP_MODE_OFF:    next_pump_on = 1'b0;
        endcase
    end

    // clock steering; the low-current rc runs while idle, trading
    // output ripple for current until a conversion needs it
    always_comb begin
        if (cfg.clk_sel) begin
            next_clk_src = cp_pkg::CP_CLK_INTERNAL;
        end else if (conversion_running) begin
            next_clk_src = cp_pkg::CP_CLK_SYS_DIV;
        end else begin
            next_clk_src = cp_pkg::CP_CLK_CONV_RC;
        end
    end

    // status flags; ready drops the same cycle the pump is turned off
    always_comb begin
        next_ready   = next_pump_on & settled_q;
        next_request = periph_request;
    end

    // register pump outputs and flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pump_on           <= 1'h0;
            pump_clk_src      <= cp_pkg::CP_CLK_CONV_RC;
            pump_ready_flag   <= 1'h0;
            pump_request_flag <= 1'h0;
        end else begin
            pump_on           <= next_pump_on;
            pump_clk_src      <= next_clk_src;
            pump_ready_flag   <= next_ready;
            pump_request_flag <= next_request;
        end
    end

    // checks on the logic above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_write_off;
        psel && penable && pready && pwrite && !pslverr && pstrb[0] && (pwdata[7:6] == 2'b00);
    endsequence

    sequence s_read_setup;
        psel && !penable && !pwrite && hit;
    endsequence

    property p_forced_on;
        cfg.mode == cp_pkg::CP_MODE_ON |=> pump_on;
    endproperty
    a_forced_on: assert property (p_forced_on) else $error("pump off in forced mode");

    property p_auto_supply;
        cfg.mode == cp_pkg::CP_MODE_AUTO |=> pump_on == !$past(above_q);
    endproperty
    a_auto_supply: assert property (p_auto_supply) else $error("auto mode ignores supply");

    property p_periph_gate;
        cfg.mode == cp_pkg::CP_MODE_PERIPH |=> pump_on == ($past(periph_enabled) && !$past(above_q));
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral mode wrong");

    property p_write_off;
        s_write_off ##1 1'b1 |=> !pump_on && !pump_ready_flag;
    endproperty
    a_write_off: assert property (p_write_off) else $error("pump on after mode cleared");

    property p_clk_internal;
        cfg.clk_sel |=> pump_clk_src == cp_pkg::CP_CLK_INTERNAL;
    endproperty
    a_clk_internal: assert property (p_clk_internal) else $error("internal clock not chosen");

    property p_clk_converter;
        !cfg.clk_sel |=> pump_clk_src ==
            ($past(conversion_running) ? cp_pkg::CP_CLK_SYS_DIV : cp_pkg::CP_CLK_CONV_RC);
    endproperty
    a_clk_converter: assert property (p_clk_converter) else $error("converter clock wrong");

    property p_thr_read;
        s_read_setup |=> prdata[cp_pkg::THR_BIT] == $past(above_q) && prdata[31:8] == 24'h0;
    endproperty
    a_thr_read: assert property (p_thr_read) else $error("threshold flag read wrong");

    property p_ready_on;
        pump_ready_flag |-> pump_on && $past(settled_q);
    endproperty
    a_ready_on: assert property (p_ready_on) else $error("ready without steady pump");

    property p_request;
        pump_request_flag == $past(periph_request);
    endproperty
    a_request: assert property (p_request) else $error("request flag stale");

    property p_mode_read;
        s_read_setup |=> prdata[7:5] == $past({cfg.mode, cfg.clk_sel}) && prdata[4:3] == 2'b00;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("control field read wrong");

    property p_sync_agree;
        $changed(above_q) |-> $past(above_sync[2] == above_sync[1]);
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("threshold accepted unsettled");

    // bus checks assume a master that follows every setup with an access;
    // a master that stretches setup would see pready too early
    sequence s_write_take;
        psel && penable && pready && pwrite && !pslverr && pstrb[0];
    endsequence

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held past access");

    property p_unmapped;
        psel && !penable && !hit |=> pready && pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_field_store;
        s_write_take |=> cfg.mode == $past(pwdata[7:6]) && cfg.clk_sel == $past(pwdata[5]);
    endproperty
    a_field_store: assert property (p_field_store) else $error("control write not stored");

    property p_lane_ignored;
        psel && penable && pready && pwrite && !pstrb[0] |=> $stable(cfg);
    endproperty
    a_lane_ignored: assert property (p_lane_ignored) else $error("write without low lane stored");

    property p_ready_rise;
        next_pump_on && settled_q |=> pump_ready_flag;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready missing on steady pump");

    property p_ready_read;
        s_read_setup |=> prdata[cp_pkg::RDY_BIT] == $past(pump_ready_flag);
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("ready flag read wrong");

    property p_request_read;
        s_read_setup |=> prdata[cp_pkg::REQ_BIT] == $past(pump_request_flag);
    endproperty
    a_request_read: assert property (p_request_read) else $error("request flag read wrong");

endmodule : cp_charge_pump_ctrl

// ### verification/cp_analog_model.sv
/*
 * cp_analog_model: pump side partner that reports the settled indication.
 * Assumes pump_on comes straight from the controller; settling is timed in ns.
 */
module cp_analog_model #(
    parameter int SETTLE_NS = 100
) (
    // pump enable in, settled indication out
    input  wire logic pump_on,
    output logic      pump_settled_async
);
    timeunit 1ns;
    timeprecision 1ps;

    int run_ns;

    // one process owns the output: it settles only after a full settle time
    // of unbroken running, and a stopped pump loses its output at once
    always begin
        pump_settled_async = 1'b0;
        @(posedge pump_on);
        run_ns = 0;
        while (pump_on === 1'b1 && run_ns < SETTLE_NS) begin
            #1;
            run_ns++;
        end
        if (pump_on === 1'b1) begin
            pump_settled_async = 1'b1;
            @(negedge pump_on);
        end
    end
endmodule : cp_analog_model

// ### verification/tb_charge_pump_controller.sv
/*
 * tb_charge_pump_controller: APB-driven checks of modes, clock steering and flags.
 * Assumes an APB slave on ref_clk and the analog model as the pump.
 */
module tb_charge_pump_controller;
    timeunit 1ns;
    timeprecision 1ps;

    logic                ref_clk = 1'b0;
    logic                rst = 1'b1;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0]         paddr = 16'h0;
    logic [31:0]         pwdata = 32'h0, prdata, rd;
    logic [3:0]          pstrb = 4'h0;
    logic                pready, pslverr, err, pump_on, pump_ready_flag, settled;
    logic                supply = 1'b0, p_en = 1'b0, p_req = 1'b0, conv = 1'b0;
    cp_pkg::cp_clk_src_t pump_clk_src;
    int                  bad_count = 0, samples_checked = 0, m, v;

    always #2.5 ref_clk = ~ref_clk;

    cp_charge_pump_ctrl u_cp_charge_pump_ctrl (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .supply_above_async(supply), .pump_settled_async(settled), .periph_enabled(p_en),
        .periph_request(p_req), .conversion_running(conv), .pump_on(pump_on), .pump_clk_src(pump_clk_src),
        .pump_ready_flag(pump_ready_flag));

    cp_analog_model u_cp_analog_model (.pump_on(pump_on), .pump_settled_async(settled));

    task end_sim;
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    // one apb transfer; request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        // values read right after the edge are those the slave shows at it
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                bad_count++;
                end_sim();
            end
            @(posedge ref_clk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic exp_on(input logic [1:0] md, input logic [1:0] in);
        case (md)
            2'h3: return 1'b1;
            2'h2: return !in[0];
            2'h1: return in[1] & !in[0];
            default: return 1'b0;
        endcase
    endfunction : exp_on

    // hang guard
    initial begin
        repeat (50000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 4'h0);
        check(rd, 32'h0);
        apb(1'b1, 16'h4030, 32'hc0, 4'hf);
        check({31'h0, err}, 32'h1);
        apb(1'b1, cp_pkg::CTRL_ADDR, 32'hc0, 4'h0);
        check({31'h0, err}, 32'h0);
        apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 4'hf);
        check(rd, 32'h0);
        for (m = 0; m < 4; m++) begin
            for (v = 0; v < 4; v++) begin
                apb(1'b1, cp_pkg::CTRL_ADDR, {24'h0, m[1:0], 6'h0}, 4'h1);
                supply <= v[0];
                p_en   <= v[1];
                repeat (10) @(posedge ref_clk);
                #1 check(pump_on, exp_on(m[1:0], v[1:0]));
                apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 4'hf);
                check(rd[7:1], {m[1:0], 4'h0, v[0]});
            end
        end
        // a supply rise must pass the synchroniser before the pump reacts
        supply <= 1'b0;
        apb(1'b1, cp_pkg::CTRL_ADDR, 32'h80, 4'h1);
        repeat (10) @(posedge ref_clk);
        #1 check(pump_on, 1'b1);
        @(posedge ref_clk);
        supply <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 check(pump_on, 1'b1);
        repeat (10) @(posedge ref_clk);
        #1 check(pump_on, 1'b0);
        @(posedge ref_clk);
        supply <= 1'b0;
        apb(1'b1, cp_pkg::CTRL_ADDR, 32'hc0, 4'h1);
        repeat (4) @(posedge ref_clk);
        #1 check(pump_ready_flag, 1'b0);
        repeat (40) @(posedge ref_clk);
        apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 4'hf);
        check(rd, 32'hc1);
        check(pump_ready_flag, 1'b1);
        apb(1'b1, cp_pkg::CTRL_ADDR, 32'h0, 4'h1);
        repeat (3) @(posedge ref_clk);
        #1 check({pump_on, pump_ready_flag}, 2'b00);
        for (v = 0; v < 4; v++) begin
            apb(1'b1, cp_pkg::CTRL_ADDR, {26'h0, v[0], 5'h0}, 4'h1);
            conv  <= v[1];
            p_req <= v[1];
            repeat (4) @(posedge ref_clk);
            #1 check(pump_clk_src, v[0] ? cp_pkg::CP_CLK_INTERNAL :
                (v[1] ? cp_pkg::CP_CLK_SYS_DIV : cp_pkg::CP_CLK_CONV_RC));
            apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 4'hf);
            check(rd[5:0], {v[0], 2'b00, v[1], 2'b00});
        end
        end_sim();
    end
endmodule : tb_charge_pump_controller
